// >>> src/rhsp_pkg.sv
// Constants, types and helpers shared by the host serial port block.
// Assumes a single 100 MHz system clock and an APB register bus.
package rhsp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int BAUD_MIN = 1200;
  localparam int DIV_W = 17;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int NUM_HEADS = 2;
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h5;
  localparam logic [2:0] BAUD_SEL_RST = 3'h5;
  localparam logic [6:0] TMO_MAX_MS = 7'h64;
  localparam logic [6:0] TMO_RST = 7'h00;
  localparam logic [7:0] CTYPE_RST = 8'h99;
  localparam logic [31:0] PWD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TMO = 8'h04;
  localparam logic [7:0] A_HEAD0 = 8'h08;
  localparam logic [7:0] A_HEAD1 = 8'h0C;
  localparam logic [7:0] A_PWD0 = 8'h10;
  localparam logic [7:0] A_PWD1 = 8'h14;
  localparam logic [7:0] A_TXDATA = 8'h18;
  localparam logic [7:0] A_RXDATA = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_CTRL_MUX = 3;
  localparam int F_HEAD_TRIG = 8;
  localparam int F_HEAD_PWM = 9;
  localparam int F_RX_VALID = 8;
  localparam int ST_OK = 0;
  localparam int ST_BAD = 1;
  localparam int ST_VER = 2;
  localparam int ST_TMO = 3;
  localparam int ST_FRM = 4;
  localparam int ST_ANN = 5;
  localparam int ST_CMD0 = 8;
  localparam int ST_CMD1 = 16;
  localparam int ST_W1C = 5;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] ANN_STATUS = 8'h32;
  localparam logic [7:0] ANN_HEAD = 8'h30;
  localparam logic [2:0] ANN_LEN = 3'h4;
  localparam logic [7:0] CMD_VER0 = 8'h56;
  localparam logic [7:0] CMD_VER1 = 8'h45;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_START = 2'b01,
    LN_DATA = 2'b11,
    LN_STOP = 2'b10
  } rhsp_line_t;

  typedef struct packed {
    logic trigger;
    logic [7:0] ctype;
  } rhsp_head_t;

  typedef struct packed {
    logic [2:0] baud_sel;
    logic mux_mode;
    logic [6:0] tmo_ms;
  } rhsp_cfg_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
    baud_div = DIV_W'(CLK_HZ / (BAUD_MIN << sel));
  endfunction : baud_div

  function automatic logic [7:0] upcase(input logic [7:0] b);
    upcase = (b >= 8'h61 && b <= 8'h7A) ? (b - 8'h20) : b;
  endfunction : upcase

  function automatic logic [7:0] ann_char(input logic [2:0] idx);
    case (idx)
      3'h0: ann_char = ANN_STATUS;
      3'h1: ann_char = ANN_HEAD;
      3'h2: ann_char = 8'(ANN_STATUS + ANN_HEAD);
      default: ann_char = CH_ETX;
    endcase
  endfunction : ann_char

endpackage : rhsp_pkg

// >>> src/rhsp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; ce freezes all state.
`timescale 1ns/1ps
module rhsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_nxt = push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1) : wr_r;
    rd_nxt = pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : rhsp_fifo

// >>> src/rhsp_serial_port.sv
// Host serial port of an RFID controller: UART, telegram checker,
// parameter store and power-up announcement behind an APB slave.
// Assumes rxd is asynchronous; nv_rst_n restores factory settings.
//
// How it works
// - six baud rates 1200..38400 doubling, chosen by a register write.
// - frame is start bit, eight data bits, one stop bit, no parity.
// - factory default baud is 38400 and survives power cycles.
// - receive timeout 0..100 ms, kept across power, zero means none.
// - password mode and password return to off and zero at power-up.
// - multiplex and trigger flags off, carrier type 99, kept across power.
// - after power-up send '2', '0', 'b', end-of-text.
// - two head channels, each optionally a trigger input.
// - telegram ends with byte sum of prior characters then 03h.
// - hash and carriage return, optional line feed, also end a telegram.
// - command letters case-blind, checksum over raw characters.
`timescale 1ns/1ps
module rhsp_serial_port import rhsp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nv_rst_n,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Status and head settings
  output logic power_fault_indicator,
  output rhsp_head_t [NUM_HEADS-1:0] head_cfg,
  output logic [NUM_HEADS-1:0] head_pwd_mode
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc, stall, wr, rd, mapped;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [31:0] rdata;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  rhsp_cfg_t cfg_r, cfg_nxt;
  rhsp_head_t [NUM_HEADS-1:0] head_r, head_nxt;
  logic [NUM_HEADS-1:0] pwm_r, pwm_nxt;
  logic [31:0] pwd_r [NUM_HEADS];
  logic [31:0] pwd_nxt [NUM_HEADS];
  logic [ST_W1C-1:0] st_r, st_nxt;
  logic [8:0] rxb_r, rxb_nxt;
  logic [2:0] ann_r, ann_nxt;
  logic [7:0] cmd0_r, cmd0_nxt, cmd1_r, cmd1_nxt;
  logic ev_byte, ev_ok, ev_bad, ev_ver, ev_tmo, ev_frm;
  logic [7:0] rx_sh_r, rx_sh_nxt;

  assign acc = psel & penable & ~pready_r;
  assign stall = pwrite & (paddr == A_TXDATA) & ~fifo_in_ready;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_STATUS);
  assign wr = acc & ~stall & pwrite & mapped;
  assign rd = acc & ~pwrite & mapped;

  always_comb begin
    case (paddr)
      A_CTRL: rdata = {28'h0, cfg_r.mux_mode, cfg_r.baud_sel};
      A_TMO: rdata = {25'h0, cfg_r.tmo_ms};
      A_HEAD0: rdata = {22'h0, pwm_r[0], head_r[0]};
      A_HEAD1: rdata = {22'h0, pwm_r[1], head_r[1]};
      A_PWD0: rdata = pwd_r[0];
      A_PWD1: rdata = pwd_r[1];
      A_RXDATA: rdata = {23'h0, rxb_r};
      A_STATUS: rdata = {8'h0, cmd1_r, cmd0_r, 2'h0, (ann_r == ANN_LEN), st_r};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Non-volatile settings
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    head_nxt = head_r;
    if (wr && paddr == A_CTRL) begin
      if (pwdata[2:0] <= BAUD_SEL_MAX) begin
        cfg_nxt.baud_sel = pwdata[2:0];
      end
      cfg_nxt.mux_mode = pwdata[F_CTRL_MUX];
    end
    if (wr && paddr == A_TMO) begin
      cfg_nxt.tmo_ms = (pwdata[6:0] > TMO_MAX_MS || pwdata[31:7] != '0) ?
                       TMO_MAX_MS : pwdata[6:0];
    end
    for (int h = 0; h < NUM_HEADS; h++) begin
      if (wr && paddr == (A_HEAD0 + 8'(4 * h))) begin
        head_nxt[h] = {pwdata[F_HEAD_TRIG], pwdata[7:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      cfg_r <= '{baud_sel: BAUD_SEL_RST, mux_mode: 1'b0, tmo_ms: TMO_RST};
      head_r <= {NUM_HEADS{1'b0, CTYPE_RST}};
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      head_r <= head_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Volatile settings, status and bus answer
  // ----------------------------------------------------------------
  always_comb begin
    pwm_nxt = pwm_r;
    pwd_nxt = pwd_r;
    for (int h = 0; h < NUM_HEADS; h++) begin
      if (wr && paddr == (A_HEAD0 + 8'(4 * h))) begin
        pwm_nxt[h] = pwdata[F_HEAD_PWM];
      end
      if (wr && paddr == (A_PWD0 + 8'(4 * h))) begin
        pwd_nxt[h] = pwdata;
      end
    end
    st_nxt = st_r;
    if (wr && paddr == A_STATUS) begin
      st_nxt = st_r & ~pwdata[ST_W1C-1:0];
    end
    st_nxt = st_nxt | {ev_frm, ev_tmo, ev_ver, ev_bad, ev_ok};
    rxb_nxt = rxb_r;
    if (rd && paddr == A_RXDATA) begin
      rxb_nxt[F_RX_VALID] = 1'b0;
    end
    if (ev_byte) begin
      rxb_nxt = {1'b1, rx_sh_r};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_r <= '0;
      for (int h = 0; h < NUM_HEADS; h++) begin
        pwd_r[h] <= PWD_RST;
      end
      st_r <= '0;
      rxb_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      pwm_r <= pwm_nxt;
      pwd_r <= pwd_nxt;
      st_r <= st_nxt;
      rxb_r <= rxb_nxt;
      pready_r <= acc & ~stall;
      pslverr_r <= acc & ~stall & ~mapped;
      prdata_r <= (acc & ~pwrite & mapped) ? rdata : 32'h0000_0000;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign power_fault_indicator = st_r[ST_FRM];
  assign head_cfg = head_r;
  assign head_pwd_mode = pwm_r;

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  rhsp_fifo #(.WIDTH(DATA_BITS), .DEPTH(TX_DEPTH)) u_txq (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(wr && paddr == A_TXDATA),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  rhsp_line_t tx_st_r, tx_st_nxt;
  logic [DIV_W-1:0] tx_cnt_r, tx_cnt_nxt, div;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic txd_r, txd_nxt;

  assign div = baud_div(cfg_r.baud_sel);
  assign fifo_out_ready = (tx_st_r == LN_IDLE) && (ann_r == ANN_LEN);

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_cnt_nxt = (tx_cnt_r == '0) ? div - 1'b1 : tx_cnt_r - 1'b1;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    txd_nxt = txd_r;
    ann_nxt = ann_r;
    case (tx_st_r)
      LN_IDLE: begin
        tx_cnt_nxt = div - 1'b1;
        if (ann_r != ANN_LEN) begin
          tx_sh_nxt = ann_char(ann_r);
          ann_nxt = ann_r + 1'b1;
          txd_nxt = 1'b0;
          tx_st_nxt = LN_START;
        end else if (fifo_out_valid) begin
          tx_sh_nxt = fifo_out_data;
          txd_nxt = 1'b0;
          tx_st_nxt = LN_START;
        end
      end
      LN_START: begin
        if (tx_cnt_r == '0) begin
          txd_nxt = tx_sh_r[0];
          tx_bit_nxt = 3'h0;
          tx_st_nxt = LN_DATA;
        end
      end
      LN_DATA: begin
        if (tx_cnt_r == '0) begin
          if (tx_bit_r == 3'h7) begin
            txd_nxt = 1'b1;
            tx_st_nxt = LN_STOP;
          end else begin
            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
            txd_nxt = tx_sh_r[1];
            tx_bit_nxt = tx_bit_r + 1'b1;
          end
        end
      end
      LN_STOP: begin
        if (tx_cnt_r == '0) begin
          tx_st_nxt = LN_IDLE;
        end
      end
      default: tx_st_nxt = LN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= LN_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      txd_r <= 1'b1;
      ann_r <= '0;
    end else if (ce) begin
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      txd_r <= txd_nxt;
      ann_r <= ann_nxt;
    end
  end

  assign txd = txd_r;

  // ----------------------------------------------------------------
  // Receiver and telegram checker
  // ----------------------------------------------------------------
  rhsp_line_t rx_st_r, rx_st_nxt;
  logic rx_s1_r, rx_s2_r, rx_d_r;
  logic [DIV_W-1:0] rx_cnt_r, rx_cnt_nxt, ms_r, ms_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic got, gerr;
  logic [7:0] sum_r, sum_nxt, prev_r, prev_nxt, last_r, last_nxt, len_r, len_nxt;
  logic hash_r, hash_nxt;
  logic [6:0] gap_r, gap_nxt;
  logic [5:0] ev_r, ev_nxt;
  logic is_ver;

  assign {ev_byte, ev_ok, ev_bad, ev_ver, ev_tmo, ev_frm} = ev_r;
  assign is_ver = (cmd0_r == CMD_VER0) && (cmd1_r == CMD_VER1);

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_cnt_r - 1'b1;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    got = 1'b0;
    gerr = 1'b0;
    case (rx_st_r)
      LN_IDLE: begin
        rx_cnt_nxt = div >> 1;
        if (rx_d_r && !rx_s2_r) begin
          rx_st_nxt = LN_START;
        end
      end
      LN_START: begin
        if (rx_cnt_r == '0) begin
          rx_cnt_nxt = div - 1'b1;
          rx_bit_nxt = 3'h0;
          rx_st_nxt = rx_s2_r ? LN_IDLE : LN_DATA;
        end
      end
      LN_DATA: begin
        if (rx_cnt_r == '0) begin
          rx_cnt_nxt = div - 1'b1;
          rx_sh_nxt = {rx_s2_r, rx_sh_r[7:1]};
          rx_bit_nxt = rx_bit_r + 1'b1;
          if (rx_bit_r == 3'h7) begin
            rx_st_nxt = LN_STOP;
          end
        end
      end
      LN_STOP: begin
        if (rx_cnt_r == '0) begin
          got = rx_s2_r;
          gerr = ~rx_s2_r;
          rx_st_nxt = LN_IDLE;
        end
      end
      default: rx_st_nxt = LN_IDLE;
    endcase

    sum_nxt = sum_r;
    prev_nxt = prev_r;
    last_nxt = last_r;
    len_nxt = len_r;
    hash_nxt = hash_r;
    cmd0_nxt = cmd0_r;
    cmd1_nxt = cmd1_r;
    ev_nxt = {got, 4'h0, gerr};
    ms_nxt = (ms_r == DIV_W'(MS_CYC - 1)) ? '0 : ms_r + 1'b1;
    gap_nxt = (ms_r == DIV_W'(MS_CYC - 1) && gap_r != 7'h7F) ? gap_r + 1'b1 : gap_r;
    if (got) begin
      gap_nxt = '0;
      if (hash_r && rx_sh_r == CH_CR) begin
        ev_nxt[4] = 1'b1;
        ev_nxt[2] = is_ver;
        len_nxt = '0;
        sum_nxt = '0;
        hash_nxt = 1'b0;
      end else if (rx_sh_r == CH_ETX && len_r != '0) begin
        ev_nxt[4] = (last_r == prev_r);
        ev_nxt[3] = (last_r != prev_r);
        ev_nxt[2] = is_ver && (last_r == prev_r);
        len_nxt = '0;
        sum_nxt = '0;
        hash_nxt = 1'b0;
      end else if (!(rx_sh_r == CH_LF && len_r == '0)) begin
        hash_nxt = (rx_sh_r == CH_HASH);
        prev_nxt = sum_r;
        sum_nxt = sum_r + rx_sh_r;
        last_nxt = rx_sh_r;
        len_nxt = (len_r == 8'hFF) ? len_r : len_r + 1'b1;
        if (len_r == 8'h00) begin
          cmd0_nxt = upcase(rx_sh_r);
          cmd1_nxt = 8'h00;
        end
        if (len_r == 8'h01) begin
          cmd1_nxt = upcase(rx_sh_r);
        end
      end
    end else if (cfg_r.tmo_ms != '0 && len_r != '0 && gap_r >= cfg_r.tmo_ms) begin
      ev_nxt[1] = 1'b1;
      len_nxt = '0;
      sum_nxt = '0;
      hash_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r <= 1'b1;
      rx_st_r <= LN_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      sum_r <= '0;
      prev_r <= '0;
      last_r <= '0;
      len_r <= '0;
      hash_r <= 1'b0;
      cmd0_r <= '0;
      cmd1_r <= '0;
      ev_r <= '0;
      ms_r <= '0;
      gap_r <= '0;
    end else if (ce) begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_d_r <= rx_s2_r;
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      sum_r <= sum_nxt;
      prev_r <= prev_nxt;
      last_r <= last_nxt;
      len_r <= len_nxt;
      hash_r <= hash_nxt;
      cmd0_r <= cmd0_nxt;
      cmd1_r <= cmd1_nxt;
      ev_r <= ev_nxt;
      ms_r <= ms_nxt;
      gap_r <= gap_nxt;
    end
  end
endmodule : rhsp_serial_port

// >>> bench/rhsp_host_model.sv
// Host terminal model: 8N1 sender and receiver at one rate.
// Assumes a 100 MHz clk from the bench.
`timescale 1ns/1ps
module rhsp_host_model #(
  parameter int DIV = 2604
) (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  initial rxd = 1'h1;
  // Idle gap, then start, data LSB first, stop; no flow control
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    repeat (gap) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask : send
  // Mid-bit sampling of the controller's output
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clk);
        b[i] = txd;
      end
      repeat (DIV) @(posedge clk);
      rx_q.push_back(b);
    end
  end
endmodule : rhsp_host_model

// >>> bench/rhsp_serial_port_properties.sv
// Checker on the serial port top ports, bound after the module.
// Assumes one clock, clk, and rst_n as its reset.
`timescale 1ns/1ps
module rhsp_serial_port_properties import rhsp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  // Clock, resets, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nv_rst_n,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and settings
  input wire logic rxd,
  input wire logic txd,
  input wire logic power_fault_indicator,
  input wire rhsp_head_t [NUM_HEADS-1:0] head_cfg,
  input wire logic [NUM_HEADS-1:0] head_pwd_mode
);
  localparam int MIN_BIT = 2604;
  logic [16:0] low_r;
  logic [16:0] low_nxt;
  logic bad_a;
  logic wr_a;
  assign bad_a = (paddr[1:0] != 2'h0) || (paddr > A_STATUS);
  assign wr_a = psel && penable && pwrite && !pready && ce;
  // Length of the current low run on txd
  always_comb begin
    low_nxt = low_r;
    if (txd) low_nxt = 17'h0;
    else if (ce && low_r != 17'h1FFFF) low_nxt = low_r + 17'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_r <= 17'h0;
    else low_r <= low_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence acc_s;
    psel && penable && !pready && ce;
  endsequence
  sequence ans_s;
    pready ##1 !pready;
  endsequence
  chk_ready_next: assert property (acc_s ##0 paddr != A_TXDATA |=> ans_s)
    else $error("pready not one cycle after access");
  chk_err_unmapped: assert property (acc_s ##0 bad_a |=> pready && pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc_s ##0 !bad_a |=> !pslverr)
    else $error("error on mapped access");
  chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_start_width: assert property ($rose(txd) |-> low_r >= MIN_BIT)
    else $error("low bit shorter than one bit time");
  chk_tx_after_reset: assert property ($rose(rst_n) && ce |-> ##[0:3] !txd)
    else $error("no announcement start after reset");
  chk_head_write: assert property ($changed(head_cfg) |-> $past(wr_a))
    else $error("head settings changed without write");
  chk_pwd_write: assert property ($changed(head_pwd_mode) |->
    $past(wr_a) && ($past(paddr) == A_HEAD0 || $past(paddr) == A_HEAD1))
    else $error("password mode changed without write");
endmodule : rhsp_serial_port_properties
bind rhsp_serial_port rhsp_serial_port_properties #(.MS_CYC(MS_CYC), .TX_DEPTH(TX_DEPTH))
  rhsp_serial_port_properties_i (.clk(clk), .rst_n(rst_n), .nv_rst_n(nv_rst_n), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
  .power_fault_indicator(power_fault_indicator), .head_cfg(head_cfg),
  .head_pwd_mode(head_pwd_mode));

// >>> bench/rhsp_serial_port_bench.sv
// Bench: APB master, register model, host link at 38400.
// Assumes rhsp_pkg, the design and the host model compiled first.
`timescale 1ns/1ps
module rhsp_serial_port_bench import rhsp_pkg::*;;
  localparam logic [7:0] REGS [6] = '{A_CTRL, A_TMO, A_HEAD0, A_HEAD1, A_PWD0, A_PWD1};
  localparam logic [7:0] BADA [3] = '{8'h24, 8'h02, 8'hFC};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic nv_rst_n = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, txd, rxd, pfi, er;
  rhsp_head_t [NUM_HEADS-1:0] head_cfg;
  logic [NUM_HEADS-1:0] pwm;
  logic [31:0] mdl [logic [7:0]];
  logic [7:0] tg[$];
  logic [7:0] fq[$];
  int err_count = 0;
  int total_checks = 0;
  int seed = 72607;
  int n;
  always #5 clk = ~clk;
  rhsp_serial_port #(.MS_CYC(300), .TX_DEPTH(16)) rhsp_serial_port_i (.clk(clk),
    .rst_n(rst_n), .nv_rst_n(nv_rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .power_fault_indicator(pfi),
    .head_cfg(head_cfg), .head_pwd_mode(pwm));
  rhsp_host_model #(.DIV(CLK_HZ / 38400)) rhsp_host_model_i (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input int lim);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < lim);
    if (pready !== 1'h1) begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 400);
    case (a)
      A_CTRL: mdl[a] = {28'h0, d[3], (d[2:0] > 3'h5) ? mdl[a][2:0] : d[2:0]};
      A_TMO: mdl[a] = (d > 32'h64) ? 32'h64 : d;
      A_HEAD0, A_HEAD1: mdl[a] = {22'h0, d[9:0]};
      A_PWD0, A_PWD1: mdl[a] = d;
      default: ;
    endcase
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, 400);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rdc
  task automatic all_regs();
    foreach (REGS[i]) rdc(REGS[i], mdl[REGS[i]]);
    for (int h = 0; h < 2; h++) begin
      chk("head", 32'(mdl[A_HEAD0 + 8'(4 * h)][8:0]), 32'(head_cfg[h]));
      chk("pwm", 32'(mdl[A_HEAD0 + 8'(4 * h)][9]), 32'(pwm[h]));
    end
    chk("fault", 32'h0, 32'(pfi));
  endtask : all_regs
  task automatic low_run(input int e);
    int k;
    k = 0;
    while (txd !== 1'h0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    n = 0;
    while (txd === 1'h0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("low run", e, n);
  endtask : low_run
  initial begin
    repeat (400000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    foreach (REGS[i]) mdl[REGS[i]] = 32'h0;
    mdl[A_CTRL] = 32'h5;
    mdl[A_HEAD0] = 32'h99;
    mdl[A_HEAD1] = 32'h99;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    nv_rst_n <= 1'h1;
    low_run(2 * (CLK_HZ / 38400));
    all_regs();
    rdc(A_STATUS, 32'h0);
    foreach (BADA[i]) begin
      apb(1'h0, BADA[i], 32'h0, 400);
      chk("slverr", 32'h1, 32'(er));
    end
    wr(A_RXDATA, 32'h1FF);
    rdc(A_RXDATA, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wr(A_CTRL, 32'(s));
      rdc(A_CTRL, mdl[A_CTRL]);
    end
    wr(A_CTRL, 32'hD);
    wr(A_TMO, 32'h7F);
    wr(A_PWD0, $random(seed));
    wr(A_PWD1, $random(seed));
    wr(A_HEAD0, $random(seed));
    wr(A_HEAD1, $random(seed));
    wr(A_CTRL, 32'hF);
    all_regs();
    tg = '{8'h23, 8'h0D, 8'h76, 8'h65};
    tg.push_back(8'(tg[2] + tg[3]));
    tg.push_back(8'h03);
    fork
      foreach (tg[i]) rhsp_host_model_i.send(tg[i], $unsigned($random(seed)) % 40);
      begin
        repeat (16) begin
          fq.push_back(8'($random(seed)));
          wr(A_TXDATA, 32'(fq[$]));
        end
        apb(1'h1, A_TXDATA, 32'h5A, 150000);
        chk("fifo full stall", 32'h1, 32'(n > 300));
      end
    join
    n = 0;
    while (rhsp_host_model_i.rx_q.size() < 5 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30000) err_count++;
    tg = '{8'h32, 8'h30, 8'h62, 8'h03};
    foreach (tg[i]) chk("announce", 32'(tg[i]), 32'(rhsp_host_model_i.rx_q[i]));
    chk("fifo byte", 32'(fq[0]), 32'(rhsp_host_model_i.rx_q[4]));
    repeat (CLK_HZ / 38400) @(posedge clk);
    rdc(A_STATUS, 32'h0045_5625);
    rdc(A_RXDATA, 32'h103);
    rdc(A_RXDATA, 32'h003);
    wr(A_STATUS, 32'h1F);
    rdc(A_STATUS, 32'h0045_5620);
    wr(A_CTRL, 32'hC);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    mdl[A_HEAD0][9] = 1'h0;
    mdl[A_HEAD1][9] = 1'h0;
    mdl[A_PWD0] = 32'h0;
    mdl[A_PWD1] = 32'h0;
    low_run(2 * (CLK_HZ / 19200));
    all_regs();
    report_and_stop();
  end
endmodule : rhsp_serial_port_bench
